// File: shared/bsc_defines.vh
// Purpose: constants of the bch stream codec
// Assumes: included by bare name from the codec source
// Notes: codewords are padded to whole words by leading zero bits
`ifndef BSC_DEFINES_VH
`define BSC_DEFINES_VH
// code shape: m, t, d, n, parity bits
`define BSC_M      14
`define BSC_T      7'd40
`define BSC_D      20
`define BSC_N      8784
`define BSC_PAR    560
// low 14 bits of the primitive polynomial 17,475
`define BSC_PRIM   14'h0443
`define BSC_Q      16383
// word counts: 440 words hold 8800 bits, 16 leading pad bits
`define BSC_NPAD   8800
`define BSC_NW     9'd440
`define BSC_KW     9'd412
`define BSC_PW     9'd28
`define BSC_BMLAST 7'd79
`define BSC_BAD    7'h7F
// register offsets and fields
`define BSC_A_CTRL 8'h00
`define BSC_A_STAT 8'h04
`define BSC_A_CNT  8'h08
`define BSC_CTRL_FIX   0
`define BSC_CTRL_RST   1'b1
`define BSC_STAT_MODE  0
`define BSC_STAT_TALLY 8
`define BSC_OKAY   2'b00
`define BSC_SLVERR 2'b10
`endif

// File: hw/bsc_codec.v
// Purpose: streaming bch encoder or decoder with axi4-lite registers
// Assumes: one clock, words enter msb first, whole codewords after reset
// Notes: DECODER selects the build; 0 gives the encoder
`timescale 1ns/1ps
`default_nettype none
`include "bsc_defines.vh"

// Overview of operation
// [R1] build as encoder by default, or decoder
// [R2] encoder moves twenty bits each way per clock
// [R3] message passes unchanged, then check words
// [R4] ready low while check words go out
// [R5] ready drops after X-1 words, last still taken
// [R6] input ignored while ready is low
// [R7] source offers words only while ready high
// [R8] one-cycle start marker on first output word
// [R9] ready and downstream accept both throttle flow
// [R10] source marks first and last input word
// [R11] shortened codes are zero-prefixed full codes
// [R12] decoder length fixed at build time
// [R13] up to t errors corrected
// [R14] input codeword spans start to end marker
// [R15] decoder takes nothing while ready is low
// [R16] output framed with valid, start, end
// [R17] decoder emits whole codeword with check bits
// [R18] error tally counts errors, all ones uncorrectable
// [R19] symbol width fourteen, polynomial from it
// [R20] decoder takes a word every cycle; here ready drops for at least one cycle after each codeword
// [R21] t is forty, 560 parity bits
// [R22] parallel width twenty bits
// [R23] reset clears the whole block; here the decoder buffer mem is not reset
// [R24] tally valid with output end marker
// [R25] output holds while downstream stalls
module bsc_codec #(
  parameter DECODER = 0 // [R1]
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // upstream stream
  input  wire [19:0] in_data, // [R22]
  input  wire        in_valid,
  input  wire        in_sop,
  input  wire        in_eop,
  output reg         in_ready,
  // downstream stream
  output reg  [19:0] out_data,
  output reg         out_valid,
  output reg         out_sop,
  output reg         out_eop,
  input  wire        out_ready,
  output reg  [6:0]  error_tally,
  // axi4-lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // field multiply, reduced by the primitive polynomial
  function [13:0] gf_mul;
    input [13:0] a;
    input [13:0] b;
    integer i;
    begin
      gf_mul = 14'h0000;
      for (i = 13; i >= 0; i = i - 1) begin
        gf_mul = {gf_mul[12:0], 1'b0} ^ (gf_mul[13] ? `BSC_PRIM : 14'h0000);
        if (b[i])
          gf_mul = gf_mul ^ a;
      end
    end
  endfunction

  // alpha to a power, square and multiply
  function [13:0] gf_pow;
    input integer e;
    integer i;
    begin
      gf_pow = 14'h0001;
      for (i = 13; i >= 0; i = i - 1) begin
        gf_pow = gf_mul(gf_pow, gf_pow);
        if (e[i])
          gf_pow = gf_mul(gf_pow, 14'h0002);
      end
    end
  endfunction

  // alpha^j for j = 1..80
  function [1119:0] mk_apow;
    input dummy;
    integer j;
    begin
      mk_apow = {1120{1'b0}};
      for (j = 1; j <= 80; j = j + 1)
        mk_apow[(j-1)*14 +: 14] = gf_pow(j);
    end
  endfunction

  // alpha^(-i(npad-1)): chien start for the first bit received
  function [559:0] mk_cinit;
    input dummy;
    integer i;
    begin
      mk_cinit = {560{1'b0}};
      for (i = 1; i <= 40; i = i + 1)
        mk_cinit[(i-1)*14 +: 14] =
          gf_pow((`BSC_Q - (i * (`BSC_NPAD - 1)) % `BSC_Q) % `BSC_Q);
    end
  endfunction

  // generator: product of minimal polynomials of odd powers
  function [560:0] mk_gen;
    input dummy;
    integer i, j, c;
    reg [209:0] mp;
    reg [13:0]  r;
    reg [560:0] acc;
    begin
      mk_gen = {{560{1'b0}}, 1'b1};
      for (i = 1; i < 80; i = i + 2) begin
        mp = {{196{1'b0}}, 14'h0001};
        for (j = 0; j < 14; j = j + 1) begin
          r = gf_pow((i << j) % `BSC_Q);
          for (c = 14; c > 0; c = c - 1)
            mp[c*14 +: 14] = mp[(c-1)*14 +: 14] ^ gf_mul(mp[c*14 +: 14], r);
          mp[13:0] = gf_mul(mp[13:0], r);
        end
        acc = {561{1'b0}};
        for (c = 0; c <= 14; c = c + 1)
          if (mp[c*14])
            acc = acc ^ (mk_gen << c);
        mk_gen = acc;
      end
    end
  endfunction

  // bank and word to memory address
  function [10:0] maddr;
    input [1:0] bank;
    input [8:0] w;
    begin
      maddr = bank * {2'b00, `BSC_NW} + {2'b00, w};
    end
  endfunction

  // register index of an address, 3 when unmapped
  function [1:0] rsel;
    input [7:0] a;
    begin
      if (a[7:2] == `BSC_A_CTRL >> 2)
        rsel = 2'd0;
      else if (a[7:2] == `BSC_A_STAT >> 2)
        rsel = 2'd1;
      else if (a[7:2] == `BSC_A_CNT >> 2)
        rsel = 2'd2;
      else
        rsel = 2'd3;
    end
  endfunction

  localparam [1119:0] APOW  = mk_apow(1'b0);  // [R19]
  localparam [559:0]  CINIT = mk_cinit(1'b0);
  localparam [560:0]  GEN   = mk_gen(1'b0);   // [R21]
  localparam E_MSG = 1'b0;
  localparam E_PAR = 1'b1;
  localparam B_IDLE = 2'd0;
  localparam B_RUN  = 2'd1;
  localparam B_DONE = 2'd2;

  // state
  reg          fix_en_r;
  reg  [7:0]   aw_addr_r;
  reg  [31:0]  w_data_r;
  reg  [3:0]   w_strb_r;
  reg  [31:0]  cw_cnt_r;
  reg          sp_v_r, sp_sop_r, sp_eop_r;
  reg  [19:0]  sp_data_r;
  reg          est_r, take_r;
  reg  [8:0]   ecnt_r, wcnt_r, ocnt_r;
  reg  [559:0] lfsr_r;
  reg          dst_r, ost_r;
  reg  [1:0]   rx_bank_r, bm_bank_r, o_bank_r, bst_r;
  reg  [2:0]   busy_r;
  reg  [1119:0] syn_r, bm_syn_r;
  reg  [573:0] lam_r, bb_r, terms_r;
  reg  [13:0]  gam_r;
  reg  [6:0]   bm_r, bl_r, ol_r, roots_r;
  reg  [19:0]  mem [0:1319];
  // combinational results
  reg          push, p_sop, p_eop;
  reg  [19:0]  p_data, fix_data;
  reg  [4:0]   nfix;
  reg  [573:0] tv, lam_nxt, xb;
  reg  [13:0]  s, delta;
  reg  [1119:0] syn_nxt;
  reg  [559:0] lfsr_nxt;
  reg          fb;
  integer      b, i, k;

  // output queue: head is the port, one spare for registered ready
  wire pop      = out_valid & out_ready;
  wire head_mov = pop | ~out_valid;
  wire can_push = ~sp_v_r | out_ready;
  wire sp_v_nxt = head_mov ? (sp_v_r & push) : (sp_v_r | push);

  // encoder handshake; take_r is the extra slot for the last word
  wire acc_e  = (est_r == E_MSG) & in_valid & (in_ready | take_r)
              & can_push; // [R5] [R6]
  wire e_end  = acc_e & (take_r | in_eop);
  wire e_pend = (est_r == E_PAR) & can_push & (ecnt_r == `BSC_PW - 9'd1);
  wire est_nxt = e_end ? E_PAR : (e_pend ? E_MSG : est_r);
  wire take_nxt = e_end ? 1'b0 :
                  (acc_e & (ecnt_r == `BSC_KW - 9'd2)) ? 1'b1 : take_r;
  // next-to-last word only into an empty head, so the last one has room
  wire ov_nxt = head_mov ? (sp_v_r | push) : out_valid;
  wire e_pre  = (est_nxt == E_MSG)
              & ((acc_e ? ecnt_r + 9'd1 : ecnt_r) == `BSC_KW - 9'd2);

  // decoder receive handshake and bank hand-off
  wire [1:0] rx_next = (rx_bank_r == 2'd2) ? 2'd0 : rx_bank_r + 2'd1;
  wire acc_d  = in_valid & in_ready & ~dst_r;              // [R15]
  wire take_d = acc_d & ((wcnt_r != 9'd0) | in_sop);       // [R14]
  wire d_end  = take_d & (in_eop | (wcnt_r == `BSC_NW - 9'd1));
  wire d_go   = dst_r & (bst_r == B_IDLE) & ~busy_r[rx_next];
  wire dst_nxt = d_end ? 1'b1 : (d_go ? 1'b0 : dst_r);
  wire [19:0] rd_word = mem[maddr(o_bank_r, ocnt_r)];
  wire [6:0] roots_sum = roots_r + {2'b00, nfix};
  wire [6:0] tally = (roots_sum == ol_r && ol_r <= `BSC_T) ?
                     ol_r : `BSC_BAD; // [R18] [R13]

  // datapath arithmetic for all stages
  always @* begin
    // chien search over the twenty bits of the word being sent
    tv = terms_r;
    fix_data = rd_word;
    nfix = 5'd0;
    for (b = 19; b >= 0; b = b - 1) begin
      s = 14'h0000;
      for (i = 0; i <= 40; i = i + 1)
        s = s ^ tv[i*14 +: 14];
      if (s == 14'h0000) begin
        nfix = nfix + 5'd1;
        if (fix_en_r)
          fix_data[b] = ~fix_data[b]; // [R13]
      end
      for (i = 1; i <= 40; i = i + 1)
        tv[i*14 +: 14] = gf_mul(tv[i*14 +: 14], APOW[(i-1)*14 +: 14]);
    end
    // syndromes by horner, msb first; restart on the first word
    syn_nxt = (wcnt_r == 9'd0) ? {1120{1'b0}} : syn_r;
    for (b = 19; b >= 0; b = b - 1)
      for (i = 0; i < 80; i = i + 1)
        syn_nxt[i*14 +: 14] = gf_mul(syn_nxt[i*14 +: 14],
          APOW[i*14 +: 14]) ^ {13'h0000, in_data[b]};
    // inversionless berlekamp-massey step
    delta = 14'h0000;
    for (i = 0; i <= 40; i = i + 1)
      if (i <= bm_r)
        delta = delta ^ gf_mul(lam_r[i*14 +: 14],
                               bm_syn_r[(bm_r - i)*14 +: 14]);
    xb = {bb_r[559:0], 14'h0000};
    for (i = 0; i <= 40; i = i + 1)
      lam_nxt[i*14 +: 14] = gf_mul(gam_r, lam_r[i*14 +: 14])
                          ^ gf_mul(delta, xb[i*14 +: 14]);
    // encoder division, one message bit at a time
    lfsr_nxt = lfsr_r;
    for (b = 19; b >= 0; b = b - 1) begin
      fb = in_data[b] ^ lfsr_nxt[559];
      lfsr_nxt = {lfsr_nxt[558:0], 1'b0} ^ (fb ? GEN[559:0] : {560{1'b0}});
    end
    // source of the next queued output word
    push   = 1'b0;
    p_data = in_data;
    p_sop  = 1'b0;
    p_eop  = 1'b0;
    if (DECODER != 0) begin
      if (ost_r && can_push) begin
        push   = 1'b1;
        p_data = fix_data;                          // [R17]
        p_sop  = (ocnt_r == 9'd0);                  // [R8] [R16]
        p_eop  = (ocnt_r == `BSC_NW - 9'd1);        // [R16]
      end
    end else if (est_r == E_PAR) begin
      push   = can_push;
      p_data = lfsr_r[559:540];                     // [R3]
      p_eop  = (ecnt_r == `BSC_PW - 9'd1);
    end else begin
      push   = acc_e;                               // [R2] [R3]
      p_sop  = (ecnt_r == 9'd0);                    // [R8]
    end
  end

  // output queue, tally and codeword count
  always @(posedge aclk) begin
    if (!aresetn) begin
      out_valid   <= 1'b0;
      out_data    <= 20'h00000;
      out_sop     <= 1'b0;
      out_eop     <= 1'b0;
      sp_v_r      <= 1'b0;
      sp_data_r   <= 20'h00000;
      sp_sop_r    <= 1'b0;
      sp_eop_r    <= 1'b0;
      error_tally <= 7'h00;
      cw_cnt_r    <= 32'h00000000;
    end else begin
      if (head_mov) begin // [R25] head moves only when free or taken
        out_valid <= sp_v_r | push;
        out_data  <= sp_v_r ? sp_data_r : p_data;
        out_sop   <= sp_v_r ? sp_sop_r : p_sop;
        out_eop   <= sp_v_r ? sp_eop_r : p_eop;
      end
      sp_v_r <= sp_v_nxt;
      if (push && (sp_v_r || !head_mov)) begin
        sp_data_r <= p_data;
        sp_sop_r  <= p_sop;
        sp_eop_r  <= p_eop;
      end
      if (push && p_eop) begin
        cw_cnt_r <= cw_cnt_r + 32'h00000001;
        if (DECODER != 0)
          error_tally <= tally; // [R24]
      end
    end
  end

  // encoder: message pass-through, then check words
  always @(posedge aclk) begin
    if (!aresetn) begin // [R23]
      est_r  <= E_MSG;
      take_r <= 1'b0;
      ecnt_r <= 9'd0;
      lfsr_r <= {560{1'b0}};
    end else if (DECODER == 0) begin
      est_r  <= est_nxt;
      take_r <= take_nxt;
      if (acc_e) begin
        lfsr_r <= lfsr_nxt;                          // [R11]
        ecnt_r <= e_end ? 9'd0 : ecnt_r + 9'd1;
      end else if (est_r == E_PAR && can_push) begin
        lfsr_r <= {lfsr_r[539:0], 20'h00000};
        ecnt_r <= e_pend ? 9'd0 : ecnt_r + 9'd1;
      end
    end
  end

  // upstream ready, registered from next state
  always @(posedge aclk) begin
    if (!aresetn)
      in_ready <= 1'b0;
    else if (DECODER == 0)
      in_ready <= (est_nxt == E_MSG) & ~take_nxt & ~sp_v_nxt
                & ~(e_pre & ov_nxt); // [R4] [R5] [R9]
    else
      in_ready <= ~dst_nxt;                          // [R20] [R9]
  end

  // decoder buffer: three banks so receive overlaps locator search and output
  always @(posedge aclk) begin
    if (take_d)
      mem[maddr(rx_bank_r, wcnt_r)] <= in_data;
  end

  // decoder receive, locator search and correction stages
  always @(posedge aclk) begin
    if (!aresetn) begin // [R23]
      dst_r     <= 1'b0;
      rx_bank_r <= 2'd0;
      wcnt_r    <= 9'd0;
      syn_r     <= {1120{1'b0}};
      busy_r    <= 3'b000;
      bst_r     <= B_IDLE;
      bm_r      <= 7'd0;
      bm_bank_r <= 2'd0;
      bm_syn_r  <= {1120{1'b0}};
      lam_r     <= {574{1'b0}};
      bb_r      <= {574{1'b0}};
      gam_r     <= 14'h0001;
      bl_r      <= 7'd0;
      ost_r     <= 1'b0;
      ocnt_r    <= 9'd0;
      o_bank_r  <= 2'd0;
      terms_r   <= {574{1'b0}};
      ol_r      <= 7'd0;
      roots_r   <= 7'd0;
    end else if (DECODER != 0) begin
      dst_r <= dst_nxt;
      // receive words and build syndromes
      if (take_d) begin
        syn_r  <= syn_nxt;
        wcnt_r <= d_end ? 9'd0 : wcnt_r + 9'd1;       // [R14] [R12]
      end
      // hand a full bank to the locator search
      if (d_go) begin
        busy_r[rx_bank_r] <= 1'b1;
        bm_bank_r <= rx_bank_r;
        rx_bank_r <= rx_next;
        bm_syn_r  <= syn_r;
        bst_r     <= B_RUN;
        bm_r      <= 7'd0;
        lam_r     <= {{560{1'b0}}, 14'h0001};
        bb_r      <= {{560{1'b0}}, 14'h0001};
        gam_r     <= 14'h0001;
        bl_r      <= 7'd0;
      end else if (bst_r == B_RUN) begin // [R13]
        lam_r <= lam_nxt;
        if (delta != 14'h0000 && {bl_r, 1'b0} <= {1'b0, bm_r}) begin
          bb_r  <= lam_r;
          bl_r  <= bm_r + 7'd1 - bl_r;
          gam_r <= delta;
        end else begin
          bb_r <= xb;
        end
        bm_r <= bm_r + 7'd1;
        if (bm_r == `BSC_BMLAST)
          bst_r <= B_DONE;
      end else if (bst_r == B_DONE && !ost_r) begin
        bst_r    <= B_IDLE;
        ost_r    <= 1'b1;
        ocnt_r   <= 9'd0;
        o_bank_r <= bm_bank_r;
        ol_r     <= bl_r;
        roots_r  <= 7'd0;
        terms_r[13:0] <= lam_r[13:0];
        for (k = 1; k <= 40; k = k + 1)
          terms_r[k*14 +: 14] <= gf_mul(lam_r[k*14 +: 14],
                                        CINIT[(k-1)*14 +: 14]);
      end
      // send corrected words in input order
      if (ost_r && can_push) begin
        terms_r <= tv;
        roots_r <= roots_sum;
        ocnt_r  <= ocnt_r + 9'd1;
        if (p_eop) begin
          ost_r <= 1'b0;
          busy_r[o_bank_r] <= 1'b0;
        end
      end
    end
  end

  // axi4-lite write channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `BSC_OKAY;
      fix_en_r      <= `BSC_CTRL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awready <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wready <= 1'b0;
      if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_bvalid  <= 1'b1;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bresp   <= (rsel(aw_addr_r) == 2'd3) ? `BSC_SLVERR : `BSC_OKAY;
        if (rsel(aw_addr_r) == 2'd0 && w_strb_r[0])
          fix_en_r <= w_data_r[`BSC_CTRL_FIX];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // held write address and data
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h00000000;
      w_strb_r  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready)
        aw_addr_r <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
    end
  end

  // axi4-lite read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `BSC_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `BSC_OKAY;
      s_axi_rdata   <= 32'h00000000;
      case (rsel(s_axi_araddr))
        2'd0: s_axi_rdata[`BSC_CTRL_FIX] <= fix_en_r;
        2'd1: begin
          s_axi_rdata[`BSC_STAT_MODE] <= (DECODER != 0);
          s_axi_rdata[`BSC_STAT_TALLY +: 7] <= error_tally;
        end
        2'd2: s_axi_rdata <= cw_cnt_r;
        default: s_axi_rresp <= `BSC_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // bsc_codec
`default_nettype wire

// File: bench/bsc_codec_props.sv
// Purpose: stream checks on the codec ports, encoder build
// Assumes: 440 output words per codeword, 411 words taken with ready
// Notes: counters track accepted words within each codeword
`timescale 1ns/1ps
`default_nettype none
module bsc_codec_props (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // upstream side
  input wire logic        in_valid,
  input wire logic        in_ready,
  // downstream side
  input wire logic [19:0] out_data,
  input wire logic        out_valid,
  input wire logic        out_sop,
  input wire logic        out_eop,
  input wire logic        out_ready,
  input wire logic [6:0]  error_tally
);
  logic [8:0] icnt_r;
  logic [8:0] ocnt_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // words taken while ready is high, and words delivered
  always @(posedge aclk) begin
    if (!aresetn) begin
      icnt_r <= 9'h000;
      ocnt_r <= 9'h000;
    end else begin
      if (in_valid && in_ready)
        icnt_r <= (icnt_r == 9'h19A) ? 9'h000 : icnt_r + 9'h001;
      if (out_valid && out_ready)
        ocnt_r <= (ocnt_r == 9'h1B7) ? 9'h000 : ocnt_r + 9'h001;
    end
  end

  AST_READY_DROP:
    assert property (in_valid && in_ready && icnt_r == 9'h19A |=> !in_ready)
      else $error("ready high after next-to-last word");
  AST_CHECK_HOLD:
    assert property (out_valid && ocnt_r >= 9'h19C && ocnt_r < 9'h1B4
      |-> !in_ready) else $error("ready high during check words");
  AST_SOP_POS:
    assert property (out_valid && out_sop |-> ocnt_r == 9'h000)
      else $error("start marker off the first word");
  AST_SOP_ONE:
    assert property (out_valid && out_sop && out_ready |=> !out_sop)
      else $error("start marker longer than one word");
  AST_EOP_POS:
    assert property (out_valid |-> out_eop == (ocnt_r == 9'h1B7))
      else $error("end marker misplaced");
  AST_HOLD:
    assert property (out_valid && !out_ready |=> out_valid
      && $stable(out_data) && $stable({out_sop, out_eop}))
      else $error("output moved while stalled");
  AST_RESET_OUT:
    assert property (disable iff (1'b0) !aresetn |=> !out_valid && !in_ready)
      else $error("stream active after reset");
  AST_TALLY_ENC:
    assert property (out_valid |-> error_tally == 7'h00)
      else $error("encoder tally not zero");
endmodule // bsc_codec_props
`default_nettype wire

// File: bench/bsc_sink.sv
// Purpose: downstream sink model for the codec output stream
// Assumes: at most 440 words stored between clears
// Notes: stalls at random when asked, else always accepts
`timescale 1ns/1ps
`default_nettype none
module bsc_sink (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // bench control
  input  wire logic        clr,
  input  wire logic        stall_en,
  // codec output stream
  input  wire logic [19:0] out_data,
  input  wire logic        out_valid,
  input  wire logic        out_sop,
  input  wire logic        out_eop,
  output var  logic        out_ready = 1'b1
);
  logic [19:0] words [0:439];
  int          count;
  int          sop_at;
  int          eop_at;

  // store words on handshake, then pick the next ready level
  always @(posedge aclk) begin
    if (!aresetn || clr) begin
      count <= 0;
      sop_at <= -1;
      eop_at <= -1;
    end else if (out_valid && out_ready) begin
      if (count < 440)
        words[count] <= out_data;
      if (out_sop)
        sop_at <= count;
      if (out_eop)
        eop_at <= count;
      count <= count + 1;
    end
    out_ready <= stall_en ? 1'($urandom % 2) : 1'b1;
  end
endmodule // bsc_sink
`default_nettype wire

// File: bench/tb_top.sv
// Purpose: self-checking bench for the codec in encoder build
// Assumes: 412 message words then 28 check words per codeword
// Notes: check words judged by odd syndromes of the whole codeword
`timescale 1ns/1ps
`default_nettype none
`include "bsc_defines.vh"
module tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [19:0] in_data = 20'h00000;
  logic        in_valid = 1'b0, in_sop = 1'b0, in_eop = 1'b0;
  logic        stall_en = 1'b0, clr = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  wire         in_ready, out_valid, out_sop, out_eop, out_ready;
  wire  [19:0] out_data;
  wire  [6:0]  error_tally;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  logic [19:0] msg [0:411];
  int          fail_count = 0;
  int          comparisons = 0;

  // encoder build under test
  bsc_codec #(.DECODER(0)) u_bsc_codec (
    .aclk, .aresetn, .in_data, .in_valid, .in_sop, .in_eop, .in_ready,
    .out_data, .out_valid, .out_sop, .out_eop, .out_ready, .error_tally,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  bsc_sink u_bsc_sink (
    .aclk, .aresetn, .clr, .stall_en, .out_data, .out_valid, .out_sop,
    .out_eop, .out_ready
  );

  // 200 MHz clock
  initial begin
    forever #2.5 aclk = ~aclk;
  end

  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("wrong value at %0t ns: %s", $time, m);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic tmo;
    chk(1'b0, "wait ran out");
    finish_test;
  endtask

  // product in the 14-bit field
  function automatic logic [13:0] gmul(input logic [13:0] a,
                                       input logic [13:0] b);
    logic [13:0] r;
    r = 14'h0000;
    for (int i = 13; i >= 0; i--) begin
      r = {r[12:0], 1'b0} ^ (r[13] ? `BSC_PRIM : 14'h0000);
      if (b[i])
        r = r ^ a;
    end
    return r;
  endfunction

  // received codeword evaluated at alpha^j, first bit highest power
  function automatic logic [13:0] synd(input int j);
    logic [13:0] aj;
    logic [13:0] s;
    aj = 14'h0001;
    s = 14'h0000;
    for (int i = 0; i < j; i++)
      aj = gmul(aj, 14'h0002);
    for (int w = 0; w < 440; w++)
      for (int b = 19; b >= 0; b--)
        s = gmul(s, aj) ^ {13'h0000, u_bsc_sink.words[w][b]};
    return s;
  endfunction

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    if (i == 50)
      tmo;
    chk(s_axi_bresp === er, "write response");
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    if (i == 50)
      tmo;
    chk(s_axi_rdata === d && s_axi_rresp === er, "read data");
  endtask

  // offer one word; the final word goes in the spare slot
  task automatic send(input logic [19:0] d, input logic s, input logic e);
    int i;
    in_data <= d;
    in_valid <= 1'b1;
    in_sop <= s;
    in_eop <= e;
    for (i = 0; i < 5000; i++) begin
      @(posedge aclk);
      if (in_ready || e)
        break;
    end
    if (i == 5000)
      tmo;
  endtask

  // main sequence
  initial begin
    int i;
    void'($urandom(99));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(`BSC_A_CTRL, 32'h00000001, `BSC_OKAY);
    axr(`BSC_A_STAT, 32'h00000000, `BSC_OKAY);
    axr(`BSC_A_CNT, 32'h00000000, `BSC_OKAY);
    axw(`BSC_A_CTRL, 32'h00000000, `BSC_OKAY);
    axr(`BSC_A_CTRL, 32'h00000000, `BSC_OKAY);
    axw(8'h0C, 32'hFFFFFFFF, `BSC_SLVERR);
    axr(8'h0C, 32'h00000000, `BSC_SLVERR);
    for (int f = 0; f < 3; f++) begin
      stall_en <= (f != 0);
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
      for (int w = 0; w < 412; w++) begin
        msg[w] = (f == 1) ? 20'hFFFFF : 20'($urandom);
        if (w == 0)
          msg[w][19:4] = 16'h0000;
        send(msg[w], w == 0, w == 411);
      end
      // offers while ready is low must be dropped
      in_data <= 20'hABCDE;
      in_eop <= 1'b0;
      repeat (20) @(posedge aclk);
      in_valid <= 1'b0;
      for (i = 0; i < 5000 && u_bsc_sink.count < 440; i++)
        @(posedge aclk);
      if (i == 5000)
        tmo;
      repeat (10) @(posedge aclk);
      chk(u_bsc_sink.count == 440, "codeword length");
      for (int w = 0; w < 412; w++)
        chk(u_bsc_sink.words[w] === msg[w], "message word");
      chk(u_bsc_sink.sop_at == 0, "start marker");
      chk(u_bsc_sink.eop_at == 439, "end marker");
      for (int j = 1; j < 80; j += 2)
        chk(synd(j) === 14'h0000, "check words");
      axr(`BSC_A_CNT, 32'(f + 1), `BSC_OKAY);
    end
    // reset in mid-codeword returns registers to reset values and clears stream
    for (int w = 0; w < 50; w++)
      send(20'($urandom), w == 0, 1'b0);
    in_valid <= 1'b0;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(`BSC_A_CNT, 32'h00000000, `BSC_OKAY);
    axr(`BSC_A_CTRL, 32'h00000001, `BSC_OKAY);
    finish_test;
  end
endmodule // tb_top

bind bsc_codec bsc_codec_props u_bsc_codec_props (
  .aclk, .aresetn, .in_valid, .in_ready, .out_data, .out_valid,
  .out_sop, .out_eop, .out_ready, .error_tally
);
`default_nettype wire
